// ---- common/station_table_defs.vh ----
`ifndef STATION_TABLE_DEFS_VH
`define STATION_TABLE_DEFS_VH

`define ROWS 1024
`define BUCKETS 4
`define ROW_BITS 10
`define MAC_BITS 48
`define VID_BITS 13
`define FRAME_VID_BITS 12
`define DIDX_BITS 6
`define PORT_COUNT 11
`define PORT_BITS 4
`define LIMIT_BITS 12
`define CNT_BITS 16

`define ENTRY_BITS 74
`define F_VALID 73
`define F_MAC_LO 25
`define F_MAC_HI 72
`define F_VID_LO 12
`define F_VID_HI 24
`define F_DIDX_LO 6
`define F_DIDX_HI 11
`define F_TYPE_LO 4
`define F_TYPE_HI 5
`define F_AGED 3
`define F_CPUCOPY 2
`define F_SRCDISC 1
`define F_VBYPASS 0

`define TYPE_NORMAL 2'h0
`define TYPE_LOCKED 2'h1
`define TYPE_IPV4MC 2'h2
`define TYPE_IPV6MC 2'h3

`define LIMIT_RESET 12'hfff

`endif

// ---- logic/station_hash.v ----
`timescale 1ns/1ns
`include "station_table_defs.vh"

// folds the 61-bit key into a row index
module station_hash (
    input wire [`MAC_BITS-1:0] mac,
    input wire [`VID_BITS-1:0] vid,
    output wire [`ROW_BITS-1:0] row
);
    wire [69:0] key;
    assign key = {9'h000, vid, mac};
    assign row = key[9:0] ^ key[19:10] ^ key[29:20] ^ key[39:30]
        ^ key[49:40] ^ key[59:50] ^ key[69:60];
endmodule // station_hash

// ---- logic/station_table_learning.v ----
`timescale 1ns/1ns
`include "station_table_defs.vh"

module station_table_learning (
    input wire clk_sys,
    input wire rst,
    // learn request, from logic on the same clock
    input wire learnReq,
    input wire [`MAC_BITS-1:0] learnMac,
    input wire [`FRAME_VID_BITS-1:0] learnVid,
    input wire [`PORT_BITS-1:0] logicalIngressPort,
    input wire learnEnable,
    input wire learnDefaultCpuCopy,
    input wire learnDefaultSrcDiscard,
    input wire learnDefaultVlanBypass,
    input wire [`PORT_COUNT*`LIMIT_BITS-1:0] perPortLearnLimit,
    // lookup request
    input wire lookupReq,
    input wire [`MAC_BITS-1:0] lookupMac,
    input wire [`VID_BITS-1:0] lookupVid,
    input wire lookupIsSource,
    // age scan
    input wire ageStart,
    output reg busy_reg,
    output reg learnDone_reg,
    output reg lookupDone_reg,
    output reg lookupHit_reg,
    output reg [`DIDX_BITS-1:0] destinationMaskIndex_reg,
    output reg processorCopy_reg,
    output reg forwardDiscard_reg,
    output reg vlanMaskBypass_reg,
    output reg [1:0] lookupType_reg,
    output reg [`MAC_BITS-1:0] lookupEntryMac_reg,
    output reg ageBusy_reg,
    output reg [`CNT_BITS-1:0] learnDropCounter_reg
);
    localparam ST_IDLE = 3'd0;
    localparam ST_LREAD = 3'd1;
    localparam ST_LACT = 3'd2;
    localparam ST_QREAD = 3'd3;
    localparam ST_QACT = 3'd4;
    localparam ST_AGE = 3'd5;
    localparam ADDR_BITS = `ROW_BITS + 2;

    // entry store, flip-flops indexed by row*4+bucket
    reg [`ENTRY_BITS-1:0] table_reg [0:`ROWS*`BUCKETS-1];
    reg [2:0] state_reg;
    reg [`ROW_BITS-1:0] row_reg;
    reg [ADDR_BITS-1:0] ageIdx_reg;
    reg [`MAC_BITS-1:0] mac_reg;
    reg [`VID_BITS-1:0] vid_reg;
    reg [`PORT_BITS-1:0] port_reg;
    reg isSource_reg;
    reg [`ENTRY_BITS-1:0] rowEntry_reg [0:`BUCKETS-1];
    reg [`LIMIT_BITS-1:0] learnedCount_reg [0:`PORT_COUNT-1];

    wire [`ROW_BITS-1:0] hashRow;
    wire [`MAC_BITS-1:0] hashMac;
    wire [`VID_BITS-1:0] hashVid;
    assign hashMac = learnReq ? learnMac : lookupMac;
    assign hashVid = learnReq ? {1'b0, learnVid} : lookupVid;

    station_hash hashUnit (
        .mac(hashMac),
        .vid(hashVid),
        .row(hashRow)
    );

    // per-bucket compare and free detect
    wire [`BUCKETS-1:0] bucketHit;
    wire [`BUCKETS-1:0] bucketFree;
    genvar b;
    generate
        for (b = 0; b < `BUCKETS; b = b + 1) begin : gBucket
            assign bucketHit[b] = rowEntry_reg[b][`F_VALID]
                && rowEntry_reg[b][`F_MAC_HI:`F_MAC_LO] == mac_reg
                && rowEntry_reg[b][`F_VID_HI:`F_VID_LO] == vid_reg;
            assign bucketFree[b] = !rowEntry_reg[b][`F_VALID];
        end
    endgenerate

    reg [1:0] hitBucket;
    reg [1:0] freeBucket;
    integer k;
    always @* begin
        hitBucket = 2'd0;
        freeBucket = 2'd0;
        for (k = `BUCKETS - 1; k >= 0; k = k - 1) begin
            if (bucketHit[k]) begin
                hitBucket = k[1:0];
            end
            if (bucketFree[k]) begin
                freeBucket = k[1:0];
            end
        end
    end

    wire [`ENTRY_BITS-1:0] hitEntry;
    wire [1:0] hitType;
    wire [`ENTRY_BITS-1:0] newEntry;
    wire [`LIMIT_BITS-1:0] portLimit;
    wire [`LIMIT_BITS-1:0] portCount;
    wire portValid;
    assign hitEntry = rowEntry_reg[hitBucket];
    assign hitType = hitEntry[`F_TYPE_HI:`F_TYPE_LO];
    assign portValid = port_reg < `PORT_COUNT;
    assign portLimit = portValid
        ? perPortLearnLimit[port_reg*`LIMIT_BITS +: `LIMIT_BITS]
        : {`LIMIT_BITS{1'b0}};
    assign portCount = portValid ? learnedCount_reg[port_reg]
        : {`LIMIT_BITS{1'b1}};
    assign newEntry = {1'b1, mac_reg, vid_reg, 2'b00, port_reg,
        `TYPE_NORMAL, 1'b0, learnDefaultCpuCopy, learnDefaultSrcDiscard,
        learnDefaultVlanBypass};

    wire [`ENTRY_BITS-1:0] ageEntry;
    wire [`DIDX_BITS-1:0] ageDidx;
    assign ageEntry = table_reg[ageIdx_reg];
    assign ageDidx = ageEntry[`F_DIDX_HI:`F_DIDX_LO];

    integer r;
    integer p;
    always @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            busy_reg <= 1'b1;
            ageBusy_reg <= 1'b0;
            learnDone_reg <= 1'b0;
            lookupDone_reg <= 1'b0;
            lookupHit_reg <= 1'b0;
            destinationMaskIndex_reg <= 6'h00;
            processorCopy_reg <= 1'b0;
            forwardDiscard_reg <= 1'b0;
            vlanMaskBypass_reg <= 1'b0;
            lookupType_reg <= 2'h0;
            lookupEntryMac_reg <= 48'h0000_0000_0000;
            learnDropCounter_reg <= 16'h0000;
            row_reg <= 10'h000;
            ageIdx_reg <= 12'h000;
            mac_reg <= 48'h0000_0000_0000;
            vid_reg <= 13'h0000;
            port_reg <= 4'h0;
            isSource_reg <= 1'b0;
            for (r = 0; r < `ROWS*`BUCKETS; r = r + 1) begin
                table_reg[r] <= 74'h0;
            end
            for (r = 0; r < `BUCKETS; r = r + 1) begin
                rowEntry_reg[r] <= 74'h0;
            end
            for (p = 0; p < `PORT_COUNT; p = p + 1) begin
                learnedCount_reg[p] <= 12'h000;
            end
        end else begin
            learnDone_reg <= 1'b0;
            lookupDone_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    // learn first, then lookup, then age scan
                    if (learnReq) begin
                        mac_reg <= learnMac;
                        vid_reg <= {1'b0, learnVid};
                        port_reg <= logicalIngressPort;
                        row_reg <= hashRow;
                        busy_reg <= 1'b1;
                        state_reg <= ST_LREAD;
                    end else if (lookupReq) begin
                        mac_reg <= lookupMac;
                        vid_reg <= lookupVid;
                        isSource_reg <= lookupIsSource;
                        row_reg <= hashRow;
                        busy_reg <= 1'b1;
                        state_reg <= ST_QREAD;
                    end else if (ageStart) begin
                        ageIdx_reg <= 12'h000;
                        ageBusy_reg <= 1'b1;
                        busy_reg <= 1'b1;
                        state_reg <= ST_AGE;
                    end else begin
                        busy_reg <= 1'b0;
                    end
                end
                ST_LREAD, ST_QREAD: begin
                    for (r = 0; r < `BUCKETS; r = r + 1) begin
                        rowEntry_reg[r] <= table_reg[{row_reg, r[1:0]}];
                    end
                    state_reg <= (state_reg == ST_LREAD) ? ST_LACT : ST_QACT;
                end
                ST_LACT: begin
                    if (|bucketHit) begin
                        if (hitType == `TYPE_NORMAL) begin
                            table_reg[{row_reg, hitBucket}][`F_AGED] <= 1'b0;
                            table_reg[{row_reg, hitBucket}]
                                [`F_DIDX_HI:`F_DIDX_LO] <= {2'b00, port_reg};
                        end else if (hitType == `TYPE_LOCKED) begin
                            table_reg[{row_reg, hitBucket}][`F_AGED] <= 1'b0;
                        end
                        // multicast types left untouched
                    end else if (learnEnable) begin
                        if (portCount >= portLimit) begin
                            // limit reached, entry silently not learned
                        end else if (|bucketFree) begin
                            table_reg[{row_reg, freeBucket}] <= newEntry;
                            learnedCount_reg[port_reg] <=
                                learnedCount_reg[port_reg] + 12'h001;
                        end else if (learnDropCounter_reg != 16'hffff) begin
                            // saturate rather than wrap
                            learnDropCounter_reg <=
                                learnDropCounter_reg + 16'h0001;
                        end
                    end
                    learnDone_reg <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                ST_QACT: begin
                    lookupHit_reg <= |bucketHit;
                    destinationMaskIndex_reg <=
                        hitEntry[`F_DIDX_HI:`F_DIDX_LO];
                    lookupType_reg <= hitType;
                    lookupEntryMac_reg <= hitEntry[`F_MAC_HI:`F_MAC_LO];
                    processorCopy_reg <= |bucketHit
                        && hitEntry[`F_CPUCOPY];
                    // only source lookups discard
                    forwardDiscard_reg <= |bucketHit && isSource_reg
                        && hitEntry[`F_SRCDISC];
                    vlanMaskBypass_reg <= |bucketHit && !isSource_reg
                        && hitEntry[`F_VBYPASS];
                    lookupDone_reg <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                ST_AGE: begin
                    // one entry per cycle; learning waits for the scan
                    if (ageEntry[`F_VALID]
                        && ageEntry[`F_TYPE_HI:`F_TYPE_LO] == `TYPE_NORMAL) begin
                        if (ageEntry[`F_AGED]) begin
                            table_reg[ageIdx_reg] <= 74'h0;
                            if (ageDidx < `PORT_COUNT
                                && learnedCount_reg[ageDidx[3:0]] != 12'h000)
                            begin
                                learnedCount_reg[ageDidx[3:0]] <=
                                    learnedCount_reg[ageDidx[3:0]] - 12'h001;
                            end
                        end else begin
                            table_reg[ageIdx_reg][`F_AGED] <= 1'b1;
                        end
                    end else if (ageEntry[`F_VALID]
                        && ageEntry[`F_TYPE_HI:`F_TYPE_LO] == `TYPE_LOCKED) begin
                        table_reg[ageIdx_reg][`F_AGED] <= 1'b1;
                    end
                    ageIdx_reg <= ageIdx_reg + 12'h001;
                    if (ageIdx_reg == 12'hfff) begin
                        ageBusy_reg <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // station_table_learning

// ---- bench/station_table_learning_sva.sv ----
`timescale 1ns/1ns
`include "station_table_defs.vh"

module station_table_learning_sva (
    input wire clk_sys,
    input wire rst,
    input wire learnReq,
    input wire lookupReq,
    input wire lookupIsSource,
    input wire ageStart,
    input wire busy_reg,
    input wire learnDone_reg,
    input wire lookupDone_reg,
    input wire lookupHit_reg,
    input wire [`DIDX_BITS-1:0] destinationMaskIndex_reg,
    input wire forwardDiscard_reg,
    input wire [1:0] lookupType_reg,
    input wire ageBusy_reg,
    input wire [`CNT_BITS-1:0] learnDropCounter_reg
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence learnTake;
        !busy_reg && learnReq;
    endsequence
    sequence lookupTake;
        !busy_reg && !learnReq && lookupReq;
    endsequence
    sequence ageTake;
        !busy_reg && !learnReq && !lookupReq && ageStart;
    endsequence

    AST_LEARN_LAT: assert property (learnTake |-> ##3 learnDone_reg)
        else $error("learn done not three cycles after take");
    AST_LOOKUP_LAT: assert property (lookupTake |-> ##3 lookupDone_reg)
        else $error("lookup done not three cycles after take");
    AST_AGE_RUN: assert property (ageTake |=> ageBusy_reg [*8])
        else $error("age scan busy not held");
    AST_DROP_STEP: assert property (($changed(learnDropCounter_reg) && !$past(rst))
        |-> learnDropCounter_reg == $past(learnDropCounter_reg) + 16'h0001)
        else $error("drop counter moved by other than one");
    AST_DONE_PULSE: assert property (learnDone_reg |=> !learnDone_reg && !lookupDone_reg)
        else $error("done pulse too long");
    AST_RESULT_HOLD: assert property (($changed(destinationMaskIndex_reg)
        || $changed(lookupHit_reg)) && !$past(rst) |-> lookupDone_reg)
        else $error("lookup result changed without done");
    AST_DEST_DISCARD: assert property (lookupDone_reg && !$past(lookupIsSource, 3)
        |-> !forwardDiscard_reg)
        else $error("discard on destination lookup");
    AST_LEARNED_TYPE: assert property (lookupDone_reg && lookupHit_reg
        |-> lookupType_reg == `TYPE_NORMAL)
        else $error("learned entry not normal type");
    AST_LEARNED_PORT: assert property (lookupDone_reg && lookupHit_reg
        |-> destinationMaskIndex_reg < 6'h0b)
        else $error("learned index not a port");
endmodule // station_table_learning_sva

bind station_table_learning station_table_learning_sva
    u_station_table_learning_sva (
    .clk_sys(clk_sys), .rst(rst), .learnReq(learnReq),
    .lookupReq(lookupReq), .lookupIsSource(lookupIsSource),
    .ageStart(ageStart), .busy_reg(busy_reg), .learnDone_reg(learnDone_reg),
    .lookupDone_reg(lookupDone_reg), .lookupHit_reg(lookupHit_reg),
    .destinationMaskIndex_reg(destinationMaskIndex_reg),
    .forwardDiscard_reg(forwardDiscard_reg), .lookupType_reg(lookupType_reg),
    .ageBusy_reg(ageBusy_reg), .learnDropCounter_reg(learnDropCounter_reg)
);

// ---- bench/req_model.sv ----
`timescale 1ns/1ns
`include "station_table_defs.vh"

module req_model (
    input wire clk_sys,
    input wire busy_reg,
    output reg learnReq,
    output reg [`MAC_BITS-1:0] learnMac,
    output reg [`FRAME_VID_BITS-1:0] learnVid,
    output reg [`PORT_BITS-1:0] logicalIngressPort,
    output reg lookupReq,
    output reg [`MAC_BITS-1:0] lookupMac,
    output reg [`VID_BITS-1:0] lookupVid,
    output reg lookupIsSource,
    output reg ageStart
);
    integer waitCnt;
    initial begin
        {learnReq, learnMac, learnVid, logicalIngressPort} = 0;
        {lookupReq, lookupMac, lookupVid, lookupIsSource, ageStart} = 0;
    end
    // requests are not queued, so only raise one once idle
    task waitIdle;
        begin
            waitCnt = 0;
            @(negedge clk_sys);
            while (busy_reg !== 1'b0 && waitCnt < 6000) begin
                @(negedge clk_sys);
                waitCnt = waitCnt + 1;
            end
        end
    endtask
    task learn(input [47:0] mac, input [11:0] vid, input [3:0] port);
        begin
            waitIdle;
            learnMac = mac;
            learnVid = vid;
            logicalIngressPort = port;
            learnReq = 1'b1;
            @(negedge clk_sys);
            learnReq = 1'b0;
        end
    endtask
    task lookup(input [47:0] mac, input [12:0] vid, input src);
        begin
            waitIdle;
            lookupMac = mac;
            lookupVid = vid;
            lookupIsSource = src;
            lookupReq = 1'b1;
            @(negedge clk_sys);
            lookupReq = 1'b0;
            waitIdle;
        end
    endtask
    task age;
        begin
            waitIdle;
            ageStart = 1'b1;
            @(negedge clk_sys);
            ageStart = 1'b0;
            waitIdle;
        end
    endtask
endmodule // req_model

// ---- bench/station_table_learning_tb.sv ----
`timescale 1ns/1ns
`include "station_table_defs.vh"

module station_table_learning_tb;
    reg clk_sys;
    reg rst;
    reg learnEnable;
    reg learnDefaultCpuCopy;
    reg learnDefaultSrcDiscard;
    reg learnDefaultVlanBypass;
    reg [`PORT_COUNT*`LIMIT_BITS-1:0] perPortLearnLimit;
    reg [9:0] i;
    wire learnReq, lookupReq, lookupIsSource, ageStart, busy_reg;
    wire [`MAC_BITS-1:0] learnMac, lookupMac, lookupEntryMac_reg;
    wire [`FRAME_VID_BITS-1:0] learnVid;
    wire [`VID_BITS-1:0] lookupVid;
    wire [`PORT_BITS-1:0] logicalIngressPort;
    wire learnDone_reg, lookupDone_reg, lookupHit_reg, ageBusy_reg;
    wire processorCopy_reg, forwardDiscard_reg, vlanMaskBypass_reg;
    wire [`DIDX_BITS-1:0] destinationMaskIndex_reg;
    wire [1:0] lookupType_reg;
    wire [`CNT_BITS-1:0] learnDropCounter_reg;
    integer failures;
    integer n_checks;
    integer cycles;

    req_model u_req_model (.clk_sys(clk_sys), .busy_reg(busy_reg),
        .learnReq(learnReq), .learnMac(learnMac), .learnVid(learnVid),
        .logicalIngressPort(logicalIngressPort), .lookupReq(lookupReq),
        .lookupMac(lookupMac), .lookupVid(lookupVid),
        .lookupIsSource(lookupIsSource), .ageStart(ageStart));
    station_table_learning u_station_table_learning (.clk_sys(clk_sys),
        .rst(rst), .learnReq(learnReq), .learnMac(learnMac),
        .learnVid(learnVid), .logicalIngressPort(logicalIngressPort),
        .learnEnable(learnEnable), .learnDefaultCpuCopy(learnDefaultCpuCopy),
        .learnDefaultSrcDiscard(learnDefaultSrcDiscard),
        .learnDefaultVlanBypass(learnDefaultVlanBypass),
        .perPortLearnLimit(perPortLearnLimit), .lookupReq(lookupReq),
        .lookupMac(lookupMac), .lookupVid(lookupVid),
        .lookupIsSource(lookupIsSource), .ageStart(ageStart),
        .busy_reg(busy_reg), .learnDone_reg(learnDone_reg),
        .lookupDone_reg(lookupDone_reg), .lookupHit_reg(lookupHit_reg),
        .destinationMaskIndex_reg(destinationMaskIndex_reg),
        .processorCopy_reg(processorCopy_reg),
        .forwardDiscard_reg(forwardDiscard_reg),
        .vlanMaskBypass_reg(vlanMaskBypass_reg),
        .lookupType_reg(lookupType_reg),
        .lookupEntryMac_reg(lookupEntryMac_reg), .ageBusy_reg(ageBusy_reg),
        .learnDropCounter_reg(learnDropCounter_reg));

    task close_out;
        begin
            $display("checks %0d failures %0d", n_checks, failures);
            if (failures == 0 && n_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task check(input [63:0] got, input [63:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("mismatch at %0t: got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task probe(input [47:0] mac, input [12:0] vid, input src, input hit,
        input [5:0] didx, input cpu, input disc, input byp);
        begin
            u_req_model.lookup(mac, vid, src);
            check(lookupHit_reg, hit);
            if (hit) begin
                check(destinationMaskIndex_reg, didx);
                check(lookupEntryMac_reg, mac);
                check(lookupType_reg, `TYPE_NORMAL);
                check(processorCopy_reg, cpu);
                check(forwardDiscard_reg, disc);
                if (!src)
                    check(vlanMaskBypass_reg, byp);
            end
        end
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            close_out;
        end
    end

    initial begin
        {failures, n_checks, cycles} = 0;
        rst = 1'b1;
        {learnEnable, learnDefaultVlanBypass} = 2'h3;
        {learnDefaultCpuCopy, learnDefaultSrcDiscard} = 2'h3;
        // port 7 may learn one station only
        perPortLearnLimit = {{3{12'hfff}}, 12'h001, {7{12'hfff}}};
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        learnDefaultVlanBypass = 1'b0;
        u_req_model.learn(48'h0000_0000_0123, 12'h005, 4'h3);
        probe(48'h0000_0000_0123, 13'h0005, 1, 1, 3, 1, 1, 0);
        probe(48'h0000_0000_0123, 13'h0005, 0, 1, 3, 1, 0, 0);
        probe(48'h0000_0000_0123, 13'h1005, 1, 0, 0, 0, 0, 0);
        u_req_model.learn(48'h0000_0000_0123, 12'h005, 4'h6);
        probe(48'h0000_0000_0123, 13'h0005, 1, 1, 6, 1, 1, 0);
        learnEnable = 1'b0;
        u_req_model.learn(48'h0000_0000_0456, 12'h0ff, 4'h2);
        probe(48'h0000_0000_0456, 13'h00ff, 0, 0, 0, 0, 0, 0);
        {learnEnable, learnDefaultVlanBypass} = 2'h3;
        {learnDefaultCpuCopy, learnDefaultSrcDiscard} = 2'h0;
        u_req_model.learn(48'h0000_0000_0456, 12'h0ff, 4'ha);
        probe(48'h0000_0000_0456, 13'h00ff, 0, 1, 10, 0, 0, 1);
        u_req_model.learn(48'h0000_0000_0789, 12'h000, 4'h7);
        u_req_model.learn(48'h0000_0000_0abc, 12'h000, 4'h7);
        u_req_model.learn(48'h0000_0000_0def, 12'h000, 4'hb);
        probe(48'h0000_0000_0789, 13'h0000, 1, 1, 7, 0, 0, 0);
        probe(48'h0000_0000_0abc, 13'h0000, 1, 0, 0, 0, 0, 0);
        probe(48'h0000_0000_0def, 13'h0000, 1, 0, 0, 0, 0, 0);
        check(learnDropCounter_reg, 16'h0000);
        // equal low slices cancel in the fold, so all five share row 0
        for (i = 1; i <= 5; i = i + 1)
            u_req_model.learn({28'h000_0000, i, i}, 12'h000, 4'h1);
        // the counter moves two edges after the take, so let the learn end
        u_req_model.waitIdle;
        check(learnDropCounter_reg, 16'h0001);
        for (i = 1; i <= 5; i = i + 1)
            probe({28'h000_0000, i, i}, 0, 1, i < 5, 1, 0, 0, 0);
        u_req_model.age;
        u_req_model.learn(48'h0000_0000_0123, 12'h005, 4'h6);
        u_req_model.age;
        probe(48'h0000_0000_0123, 13'h0005, 1, 1, 6, 1, 1, 0);
        probe(48'h0000_0000_0456, 13'h00ff, 1, 0, 0, 0, 0, 0);
        u_req_model.learn(48'h0000_0000_0abc, 12'h000, 4'h7);
        probe(48'h0000_0000_0abc, 13'h0000, 1, 1, 7, 0, 0, 0);
        close_out;
    end
endmodule // station_table_learning_tb
